// [design/data_space_decoder.sv]
// Data-space decoder: address generation, region routing, strobes and access timing.
`timescale 1ns/10ps
`default_nettype none
module data_space_decoder (
  input wire logic mclk, // CPU clock, 20 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic compatModePin, // Mode strap from outside, sampled at reset.
  input wire logic extMemEnable, // External-memory enable bit of cpu_control_reg.
  input wire logic [1:0] waitStates, // Configured external wait-states, 0 to 3.
  input wire data_space_pkg::access_req_t req, // Access request from the core.
  input wire logic [15:0] ptrX, // Current X pointer pair.
  input wire logic [15:0] ptrY, // Current Y pointer pair.
  input wire logic [15:0] ptrZ, // Current Z pointer pair.
  input wire logic [7:0] extRdata, // Read data from external SRAM.
  input wire logic [7:0] intRdata, // Read data from the internal target.
  output logic busy, // High while an access is in progress.
  output logic done, // One-cycle pulse when the access ends.
  output logic refused, // One-cycle pulse when an access is dropped.
  output logic [15:0] addrOut, // Effective address of the current access.
  output data_space_pkg::region_t regionOut, // Region of the current access.
  output logic intSel, // Internal target select.
  output logic intWrite, // Internal target write.
  output logic [7:0] wdataOut, // Write data.
  output logic [7:0] rdataOut, // Read data, valid with done.
  output logic ext_read_strobe_pin_n, // External read strobe, active low.
  output logic ext_write_strobe_pin_n, // External write strobe, active low.
  output logic [3:0] extraCycles, // Cycles charged beyond the internal figure.
  output data_space_pkg::ptr_update_t ptrUpd // Pointer write-back pulse.
);

  logic compatSync1_q;
  logic compatSync2_q;
  logic compatMode_q;
  logic [15:0] ptrBase;
  logic [15:0] effAddr;
  logic [15:0] extBase;
  logic [15:0] ptrNext;
  logic ptrWrite;
  data_space_pkg::region_t region;
  logic [3:0] cnt_q;
  logic [3:0] charge;
  logic extAcc_q;
  logic write_q;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INT,
    ST_EXT
  } state_t;
  state_t state_q;

  // Selects the pointer pair named by the request.
  function automatic logic [15:0] pick_ptr(input data_space_pkg::ptr_sel_t sel, input logic [15:0] x,
                                           input logic [15:0] y, input logic [15:0] z);
    unique case (sel)
      data_space_pkg::PTR_X: pick_ptr = x;
      data_space_pkg::PTR_Y: pick_ptr = y;
      data_space_pkg::PTR_Z: pick_ptr = z;
      default: pick_ptr = z;
    endcase
  endfunction

  // Extra cycles for one byte or for a two-byte program counter transfer.
  function automatic logic [3:0] extra_for(input logic stackPc, input logic [1:0] ws);
    logic [3:0] w;
    w = {2'h0, ws};
    if (ws == 2'h0)
    begin
      extra_for = stackPc ? data_space_pkg::EXT_STACK_EXTRA : data_space_pkg::EXT_BYTE_EXTRA;
    end
    else if (stackPc)
    begin
      extra_for = data_space_pkg::WAIT_STACK_BASE + (w << 1);
    end
    else
    begin
      extra_for = data_space_pkg::WAIT_BYTE_BASE + w;
    end
  endfunction

  // The mode strap is a pin, so it passes two flops before being latched.
  always_ff @(posedge mclk)
  begin
    compatSync1_q <= compatModePin;
    compatSync2_q <= compatSync1_q;
  end

  // Mode is captured while reset is held and frozen afterwards; mid-run changes are ignored.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      compatMode_q <= compatSync2_q;
    end
  end

  // Effective address from the five addressing forms.
  always_comb
  begin
    ptrBase = pick_ptr(req.ptr, ptrX, ptrY, ptrZ);
    ptrNext = ptrBase;
    ptrWrite = 1'b0;
    effAddr = ptrBase;
    unique case (req.mode)
      data_space_pkg::MODE_DIRECT: effAddr = req.directAddr;
      data_space_pkg::MODE_INDIRECT: effAddr = ptrBase;
      data_space_pkg::MODE_DISPLACED:
      begin
        // X, Y and Z all take the displacement; the offset is unsigned and at most 63.
        effAddr = ptrBase + {10'h000, req.disp & data_space_pkg::DISP_MAX};
      end
      data_space_pkg::MODE_PREDEC:
      begin
        ptrNext = ptrBase - 16'h0001;
        effAddr = ptrNext;
        ptrWrite = 1'b1;
      end
      data_space_pkg::MODE_POSTINC:
      begin
        ptrNext = ptrBase + 16'h0001;
        effAddr = ptrBase;
        ptrWrite = 1'b1;
      end
      default: effAddr = ptrBase;
    endcase
  end

  region_decode u_decode (
    .addr(effAddr),
    .compatMode(compatMode_q),
    .ioPortOp(req.ioPortOp),
    .region(region),
    .extBase(extBase)
  );

  assign charge = extra_for(req.stackPc, waitStates);

  // Access sequencer: internal takes the fixed two cycles, external adds the charged cycles.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      addrOut <= 16'h0000;
      regionOut <= data_space_pkg::REGION_NONE;
      intSel <= 1'b0;
      intWrite <= 1'b0;
      wdataOut <= 8'h00;
      extraCycles <= 4'h0;
      extAcc_q <= 1'b0;
      write_q <= 1'b0;
      ptrUpd <= '0;
    end
    else
    begin
      done <= 1'b0;
      refused <= 1'b0;
      ptrUpd.valid <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (req.valid)
          begin
            addrOut <= effAddr;
            regionOut <= region;
            wdataOut <= req.wdata;
            write_q <= req.write;
            ptrUpd.ptr <= req.ptr;
            ptrUpd.value <= ptrNext;
            ptrUpd.valid <= ptrWrite;
            if (region == data_space_pkg::REGION_NONE ||
                (region == data_space_pkg::REGION_EXT_SRAM && !extMemEnable))
            begin
              refused <= 1'b1;
              extraCycles <= 4'h0;
            end
            else if (region == data_space_pkg::REGION_EXT_SRAM)
            begin
              // External cost counts from the internal two-cycle baseline.
              state_q <= ST_EXT;
              busy <= 1'b1;
              extAcc_q <= 1'b1;
              extraCycles <= charge;
              cnt_q <= data_space_pkg::INT_SRAM_CYCLES + charge;
            end
            else
            begin
              state_q <= ST_INT;
              busy <= 1'b1;
              intSel <= 1'b1;
              intWrite <= req.write;
              extraCycles <= 4'h0;
              // Busy stands for the full two-cycle internal access, so done follows the second cycle.
              cnt_q <= data_space_pkg::INT_SRAM_CYCLES;
            end
          end
        end
        ST_INT, ST_EXT:
        begin
          if (cnt_q == 4'h1)
          begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            intSel <= 1'b0;
            intWrite <= 1'b0;
            extAcc_q <= 1'b0;
            cnt_q <= 4'h0;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Strobes only move for an enabled external access; internal ones leave them high.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ext_read_strobe_pin_n <= 1'b1;
      ext_write_strobe_pin_n <= 1'b1;
    end
    else
    begin
      ext_read_strobe_pin_n <= !(state_q == ST_EXT && extAcc_q && !write_q && cnt_q > 4'h1 && extMemEnable);
      ext_write_strobe_pin_n <= !(state_q == ST_EXT && extAcc_q && write_q && cnt_q > 4'h1 && extMemEnable);
    end
  end

  // Read data is taken from the source that served the access.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rdataOut <= 8'h00;
    end
    else if (busy && cnt_q == 4'h1)
    begin
      rdataOut <= extAcc_q ? extRdata : intRdata;
    end
  end

endmodule
`default_nettype wire

// [design/data_space_pkg.sv]
// Package with the data-space map, addressing forms and access timing for the data space decoder.
// What this block does
// - Normal mode: 32 register, 64 I/O, 160 extended I/O, 4096 SRAM locations.
// - Compatibility mode: 32 register, 64 I/O, then 4000 SRAM; lowest 4096 internal.
// - Extended I/O $60..$FF answers only data-space loads and stores, not port instructions.
// - Compatibility mode has no extended I/O; those addresses decode as internal SRAM.
// - External SRAM starts right after internal SRAM and runs to the top of 64K.
// - Addresses beyond internal memory go external, using the same load/store/push/pop operations.
// - Read and write strobes stay inactive throughout every internal access.
// - External accesses happen only while the external-memory enable bit is set.
// - Without wait-states each external byte costs one cycle more than internal.
// - Stack external, no wait-states: calls, returns, interrupts cost three extra cycles.
// - One, two, three wait-states: single external byte costs two, three, four extra.
// - Stack external with wait-states: calls, returns, interrupts cost five, seven, nine extra.
// - Five addressing forms; register entries 26 to 31 act as pointer pairs.
// - Displacement adds an unsigned offset of up to 63 to X, Y or Z.
// - Pre-decrement updates the pointer before use; post-increment updates it after use.
// - Direct addressing reaches the whole data space.
// - An internal SRAM access completes within two CPU clock cycles.
package data_space_pkg;

  localparam int ADDR_W = 16;
  localparam logic [15:0] REG_FILE_BASE = 16'h0000;
  localparam logic [15:0] STD_IO_BASE = 16'h0020;
  localparam logic [15:0] EXT_IO_BASE = 16'h0060;
  localparam logic [15:0] EXT_IO_LAST = 16'h00ff;
  localparam logic [15:0] NORMAL_SRAM_BASE = 16'h0100;
  localparam logic [15:0] NORMAL_EXT_BASE = 16'h1100;
  localparam logic [15:0] COMPAT_EXT_BASE = 16'h1000;
  localparam logic [15:0] ADDR_MAX = 16'hffff;

  // Pointer pair numbers inside the register file.
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [5:0] DISP_MAX = 6'h3f;

  // Cycle counts.
  localparam logic [3:0] INT_SRAM_CYCLES = 4'h2;
  localparam logic [3:0] EXT_BYTE_EXTRA = 4'h1;
  localparam logic [3:0] EXT_STACK_EXTRA = 4'h3;
  localparam logic [3:0] WAIT_BYTE_BASE = 4'h1;
  localparam logic [3:0] WAIT_STACK_BASE = 4'h3;
  localparam logic [1:0] WAIT_MAX = 2'h3;

  typedef enum logic [2:0] {
    REGION_REGFILE,
    REGION_STDIO,
    REGION_EXTIO,
    REGION_INT_SRAM,
    REGION_EXT_SRAM,
    REGION_NONE
  } region_t;

  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_DISPLACED,
    MODE_PREDEC,
    MODE_POSTINC
  } addr_mode_t;

  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } ptr_sel_t;

  // One request from the CPU core.
  typedef struct packed {
    logic valid;
    logic write;
    logic ioPortOp;
    logic stackPc;
    addr_mode_t mode;
    ptr_sel_t ptr;
    logic [5:0] disp;
    logic [15:0] directAddr;
    logic [7:0] wdata;
  } access_req_t;

  // Register-file pointer update returned to the core.
  typedef struct packed {
    logic valid;
    ptr_sel_t ptr;
    logic [15:0] value;
  } ptr_update_t;

endpackage

// [design/region_decode.sv]
// Combinational address-to-region decoder for the data space.
`timescale 1ns/10ps
`default_nettype none
module region_decode (
  input wire logic [15:0] addr, // Data-space address.
  input wire logic compatMode, // High in compatibility mode.
  input wire logic ioPortOp, // High for short I/O-port instructions.
  output data_space_pkg::region_t region, // Decoded target.
  output logic [15:0] extBase // First external address for this mode.
);

  // Lower bounds are checked from the top so the first match is the owning region.
  always_comb
  begin
    extBase = compatMode ? data_space_pkg::COMPAT_EXT_BASE : data_space_pkg::NORMAL_EXT_BASE;
    if (addr >= extBase)
    begin
      region = data_space_pkg::REGION_EXT_SRAM;
    end
    else if (addr >= data_space_pkg::EXT_IO_BASE)
    begin
      if (compatMode)
      begin
        region = data_space_pkg::REGION_INT_SRAM;
      end
      else if (addr <= data_space_pkg::EXT_IO_LAST)
      begin
        region = ioPortOp ? data_space_pkg::REGION_NONE : data_space_pkg::REGION_EXTIO;
      end
      else
      begin
        region = data_space_pkg::REGION_INT_SRAM;
      end
    end
    else if (addr >= data_space_pkg::STD_IO_BASE)
    begin
      region = data_space_pkg::REGION_STDIO;
    end
    else
    begin
      region = data_space_pkg::REGION_REGFILE;
    end
  end

endmodule
`default_nettype wire

// [verif/data_space_decoder_asserts.sv]
// Port assertions for the data space decoder.
`timescale 1ns/10ps
`default_nettype none
module data_space_decoder_asserts (
  input wire logic mclk, // Clock.
  input wire logic srst, // Reset.
  input wire logic compatModePin, // Strap.
  input wire logic extMemEnable, // External-memory enable.
  input wire logic [1:0] waitStates, // Wait-states.
  input wire data_space_pkg::access_req_t req, // Request.
  input wire logic [15:0] ptrX, // X pair.
  input wire logic [15:0] ptrY, // Y pair.
  input wire logic [15:0] ptrZ, // Z pair.
  input wire logic busy, // Busy.
  input wire logic done, // Done.
  input wire logic refused, // Refused.
  input wire logic [15:0] addrOut, // Address.
  input wire data_space_pkg::region_t regionOut, // Region.
  input wire logic intSel, // Internal select.
  input wire logic ext_read_strobe_pin_n, // Read strobe.
  input wire logic ext_write_strobe_pin_n, // Write strobe.
  input wire logic [3:0] extraCycles, // Extra cost.
  input wire data_space_pkg::ptr_update_t ptrUpd // Pointer update.
);
  logic compatQ;
  logic [3:0] busyLen;
  logic [15:0] ptrSel;
  // Mode counts only while reset holds, so a later strap change must not move the map.
  always_ff @(posedge mclk)
  begin
    if (srst)
      compatQ <= compatModePin;
  end
  // Busy length of the running access, still readable in the done cycle.
  always_ff @(posedge mclk)
  begin
    if (srst || !busy)
      busyLen <= 4'h0;
    else
      busyLen <= busyLen + 4'h1;
  end
  // Pointer pair named by the request.
  assign ptrSel = (req.ptr == data_space_pkg::PTR_X) ? ptrX : (req.ptr == data_space_pkg::PTR_Y) ? ptrY : ptrZ;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence s_take;
    req.valid && !busy;
  endsequence
  sequence s_start;
    $rose(busy);
  endsequence
  AST_INT_STROBES: assert property (intSel |-> ext_read_strobe_pin_n && ext_write_strobe_pin_n)
    else $error("strobe active during internal access");
  AST_EXT_ENABLE: assert property (s_start ##0 regionOut == data_space_pkg::REGION_EXT_SRAM |-> $past(extMemEnable))
    else $error("external access without enable");
  AST_COST: assert property (done |-> busyLen == data_space_pkg::INT_SRAM_CYCLES + extraCycles)
    else $error("access length differs from cost");
  AST_EXTRA: assert property (s_start ##0 regionOut == data_space_pkg::REGION_EXT_SRAM |-> extraCycles ==
    ($past(req.stackPc) ? 4'h3 + {1'b0, $past(waitStates), 1'b0} : 4'h1 + {2'h0, $past(waitStates)}))
    else $error("wrong extra cycles");
  AST_MAP_NORMAL: assert property (s_start ##0 !compatQ |-> regionOut == (addrOut < 16'h0020 ? data_space_pkg::REGION_REGFILE :
    addrOut < 16'h0060 ? data_space_pkg::REGION_STDIO : addrOut < 16'h0100 ? data_space_pkg::REGION_EXTIO :
    addrOut < 16'h1100 ? data_space_pkg::REGION_INT_SRAM : data_space_pkg::REGION_EXT_SRAM))
    else $error("normal map wrong");
  AST_MAP_COMPAT: assert property (s_start ##0 compatQ && addrOut >= 16'h0060 |-> regionOut ==
    (addrOut < 16'h1000 ? data_space_pkg::REGION_INT_SRAM : data_space_pkg::REGION_EXT_SRAM))
    else $error("compat map wrong");
  AST_IO_REFUSE: assert property (s_take ##0 (req.ioPortOp && !compatQ && req.mode == data_space_pkg::MODE_DIRECT &&
    req.directAddr inside {[16'h0060:16'h00ff]}) |-> ##1 refused && !busy)
    else $error("port access to extended I/O not refused");
  AST_PREDEC: assert property (s_take ##0 req.mode == data_space_pkg::MODE_PREDEC |-> ##1 refused ||
    (addrOut == $past(ptrSel) - 16'h1 && ptrUpd.valid && ptrUpd.value == addrOut))
    else $error("pre-decrement wrong");
  AST_POSTINC: assert property (s_take ##0 req.mode == data_space_pkg::MODE_POSTINC |-> ##1 refused ||
    (addrOut == $past(ptrSel) && ptrUpd.valid && ptrUpd.value == addrOut + 16'h1))
    else $error("post-increment wrong");
  AST_DISP: assert property (s_take ##0 req.mode == data_space_pkg::MODE_DISPLACED |-> ##1 refused ||
    addrOut == $past(ptrSel) + {10'h0, $past(req.disp)})
    else $error("displacement wrong");
endmodule
bind data_space_decoder data_space_decoder_asserts chk (.*);
`default_nettype wire

// [verif/ext_sram_model.sv]
// Behavioural external byte SRAM on the parallel memory bus.
`timescale 1ns/10ps
`default_nettype none
module ext_sram_model (
  input wire logic mclk, // Bus clock.
  input wire logic [15:0] addr, // Byte address.
  input wire logic rdStrobeN, // Read strobe, active low.
  input wire logic wrStrobeN, // Write strobe, active low.
  input wire logic [7:0] wdata, // Write data.
  output logic [7:0] rdata // Read data.
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  // Only the low address byte is decoded, enough for a few test locations.
  always @(posedge mclk)
  begin
    if (!wrStrobeN)
      mem[addr[7:0]] <= wdata;
    if (!rdStrobeN)
      last <= mem[addr[7:0]];
  end
  // A released bus shows the inverse of the last byte so stale data cannot pass.
  assign rdata = !rdStrobeN ? mem[addr[7:0]] : ~last;
endmodule
`default_nettype wire

// [verif/tb_data_space_decoder.sv]
// Testbench for the data space decoder with an external SRAM model.
`timescale 1ns/10ps
`default_nettype none
module tb_data_space_decoder;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic compatModePin = 1'b0;
  logic extMemEnable = 1'b0;
  logic [1:0] waitStates = 2'h0;
  data_space_pkg::access_req_t req = '0;
  logic [15:0] ptrX = 16'h0000;
  logic [15:0] ptrY = 16'h0000;
  logic [15:0] ptrZ = 16'h0000;
  logic [7:0] intRdata = 8'h3c;
  logic [7:0] extRdata, wdataOut, rdataOut;
  logic busy, done, refused, intSel, rdN, wrN, gotRef;
  logic [15:0] addrOut;
  logic [3:0] extraCycles;
  data_space_pkg::region_t regionOut;
  data_space_pkg::ptr_update_t ptrUpd, upd;
  int errors = 0;
  int num_checks = 0;
  int cyc;
  data_space_decoder uut (.mclk(mclk), .srst(srst), .compatModePin(compatModePin), .extMemEnable(extMemEnable),
    .waitStates(waitStates), .req(req), .ptrX(ptrX), .ptrY(ptrY), .ptrZ(ptrZ), .extRdata(extRdata),
    .intRdata(intRdata), .busy(busy), .done(done), .refused(refused), .addrOut(addrOut), .regionOut(regionOut),
    .intSel(intSel), .intWrite(), .wdataOut(wdataOut), .rdataOut(rdataOut), .ext_read_strobe_pin_n(rdN),
    .ext_write_strobe_pin_n(wrN), .extraCycles(extraCycles), .ptrUpd(ptrUpd));
  ext_sram_model mem (.mclk(mclk), .addr(addrOut), .rdStrobeN(rdN), .wrStrobeN(wrN), .wdata(wdataOut),
    .rdata(extRdata));
  // Free-running clock.
  always #25 mclk = ~mclk;
  task automatic finish_test();
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic c);
    compatModePin = c;
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
  endtask
  // One request; cyc counts falling edges from acceptance to done or refusal.
  task automatic acc(input data_space_pkg::addr_mode_t m, input data_space_pkg::ptr_sel_t p, input logic [5:0] d,
    input logic [15:0] a, input logic wr, input logic io, input logic stk);
    req = '{1'b1, wr, io, stk, m, p, d, a, 8'h5a};
    @(posedge mclk);
    @(negedge mclk);
    req.valid = 1'b0;
    upd = ptrUpd;
    cyc = 1;
    while (!done && !refused && cyc < 40)
    begin
      @(negedge mclk);
      cyc++;
    end
    gotRef = refused;
    if (cyc >= 40)
    begin
      errors++;
      finish_test();
    end
    if (gotRef)
      @(negedge mclk);
  endtask
  task automatic dr(input logic [15:0] a, input logic io);
    acc(data_space_pkg::MODE_DIRECT, data_space_pkg::PTR_X, 6'h0, a, 1'b0, io, 1'b0);
  endtask
  task automatic t_map();
    logic [15:0] a [7] = '{16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00ff, 16'h0100, 16'h10ff};
    data_space_pkg::region_t r [7] = '{data_space_pkg::REGION_REGFILE, data_space_pkg::REGION_STDIO,
      data_space_pkg::REGION_STDIO, data_space_pkg::REGION_EXTIO, data_space_pkg::REGION_EXTIO,
      data_space_pkg::REGION_INT_SRAM, data_space_pkg::REGION_INT_SRAM};
    for (int i = 0; i < 7; i++)
    begin
      dr(a[i], 1'b0);
      chk("region", 16'(r[i]), 16'(regionOut));
      chk("cycles", 16'h3, 16'(cyc));
      chk("rdata", 16'h3c, 16'(rdataOut));
    end
  endtask
  task automatic t_io();
    dr(16'h0080, 1'b1);
    chk("refused", 16'h1, 16'(gotRef));
    dr(16'h0040, 1'b1);
    chk("region", 16'(data_space_pkg::REGION_STDIO), 16'(regionOut));
    compatModePin = 1'b1;
    dr(16'h0060, 1'b0);
    chk("region", 16'(data_space_pkg::REGION_EXTIO), 16'(regionOut));
    compatModePin = 1'b0;
  endtask
  task automatic t_ptr();
    ptrX = 16'h0201;
    ptrY = 16'h0400;
    ptrZ = 16'h0300;
    acc(data_space_pkg::MODE_PREDEC, data_space_pkg::PTR_X, 6'h0, 16'h0, 1'b0, 1'b0, 1'b0);
    chk("predec addr", 16'h0200, addrOut);
    chk("predec upd", 16'h0200, upd.value);
    chk("predec ptr", 16'(data_space_pkg::PTR_X), 16'(upd.ptr));
    acc(data_space_pkg::MODE_POSTINC, data_space_pkg::PTR_Z, 6'h0, 16'h0, 1'b1, 1'b0, 1'b0);
    chk("postinc addr", 16'h0300, addrOut);
    chk("postinc upd", 16'h0301, upd.value);
    acc(data_space_pkg::MODE_DISPLACED, data_space_pkg::PTR_Y, 6'h3f, 16'h0, 1'b0, 1'b0, 1'b0);
    chk("disp addr", 16'h043f, addrOut);
    acc(data_space_pkg::MODE_INDIRECT, data_space_pkg::PTR_X, 6'h0, 16'h0, 1'b0, 1'b0, 1'b0);
    chk("ind addr", 16'h0201, addrOut);
  endtask
  task automatic t_ext();
    logic [3:0] ex;
    dr(16'h1100, 1'b0);
    chk("refused", 16'h1, 16'(gotRef));
    extMemEnable = 1'b1;
    acc(data_space_pkg::MODE_DIRECT, data_space_pkg::PTR_X, 6'h0, 16'h1100, 1'b1, 1'b0, 1'b0);
    dr(16'h1100, 1'b0);
    chk("ext rdata", 16'h5a, 16'(rdataOut));
    for (int s = 0; s < 2; s++)
      for (int w = 0; w < 4; w++)
      begin
        waitStates = 2'(w);
        ex = (s == 1) ? 4'(3 + 2 * w) : 4'(1 + w);
        acc(data_space_pkg::MODE_DIRECT, data_space_pkg::PTR_X, 6'h0, 16'hffff, 1'b0, 1'b0, s[0]);
        chk("ext cost", 16'(2 + ex), 16'(cyc - 1));
        chk("extra", 16'(ex), 16'(extraCycles));
      end
  endtask
  task automatic t_compat();
    dr(16'h0060, 1'b0);
    chk("region", 16'(data_space_pkg::REGION_INT_SRAM), 16'(regionOut));
    dr(16'h0fff, 1'b0);
    chk("region", 16'(data_space_pkg::REGION_INT_SRAM), 16'(regionOut));
    dr(16'h1000, 1'b0);
    chk("region", 16'(data_space_pkg::REGION_EXT_SRAM), 16'(regionOut));
  endtask
  // Main sequence: normal mode first, then compatibility mode after a second reset.
  initial
  begin
    do_reset(1'b0);
    t_map();
    t_io();
    t_ptr();
    t_ext();
    do_reset(1'b1);
    t_compat();
    finish_test();
  end
endmodule
`default_nettype wire
